// file: design/icw_defs.svh
`ifndef ICW_DEFS_SVH
`define ICW_DEFS_SVH

// watchdog down-counter geometry
`define ICW_CNT_W 16
`define ICW_CNT_INIT 16'hffff
`define ICW_CNT_ZERO 16'h0000

// cycles the reset pin is pulled low by a watchdog fire
`define ICW_PULL_CYCLES 8

// synchroniser idle values
`define ICW_SYNC_RST 2'b00
`define ICW_PIN_IDLE 1'b1

`endif

// file: design/icw_down_counter.sv
`include "icw_defs.svh"

module icw_down_counter import icw_pkg::*; #(
  parameter int unsigned WIDTH = `ICW_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic reload,
  output logic [WIDTH-1:0] count_q,
  output logic underflow_q
);

  logic [WIDTH-1:0] count_d;
  logic underflow_d;

  always_comb begin
    count_d = count_q;
    underflow_d = 1'b0;
    if (reload) begin
      count_d = {WIDTH{1'b1}};
    end else if (tick) begin
      if (count_q == {WIDTH{1'b0}}) begin
        // wrap to all ones so successive underflows are a full period apart
        count_d = {WIDTH{1'b1}};
        underflow_d = 1'b1;
      end else begin
        count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {WIDTH{1'b1}};
      underflow_q <= 1'b0;
    end else begin
      count_q <= count_d;
      underflow_q <= underflow_d;
    end
  end

endmodule

// file: design/icw_pkg.sv
`include "icw_defs.svh"

package icw_pkg;

  // operation code of the instruction the core retires
  typedef enum logic [1:0] {
    ICW_OP_OTHER   = 2'b00,
    ICW_OP_SERVICE = 2'b01,
    ICW_OP_DISABLE = 2'b10
  } icw_op_t;

  // one retired instruction, exec is a one-cycle strobe
  typedef struct packed {
    logic    exec;
    icw_op_t op;
  } icw_instr_t;

  // gray along run -> pull -> wait-release; wait-release -> run flips both bits
  typedef enum logic [1:0] {
    ICW_ST_RUN  = 2'b00,
    ICW_ST_PULL = 2'b01,
    ICW_ST_WAIT = 2'b11
  } icw_state_t;

endpackage

// file: design/icw_watchdog.sv
`include "icw_defs.svh"

module icw_watchdog import icw_pkg::*; #(
  parameter int unsigned CNT_W = `ICW_CNT_W,
  parameter int unsigned PULL_CYCLES = `ICW_PULL_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cycle_tick,
  input wire icw_instr_t instr,
  input wire logic sys_reset_req,
  input wire logic ram_backup_entry,
  input wire logic pd_entry,
  input wire logic pd_return,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic skip_next,
  output logic wd_enable_flag,
  output logic first_underflow_flag,
  output logic second_underflow_flag,
  output logic [CNT_W-1:0] wd_count
);

  localparam int unsigned PW = $clog2(PULL_CYCLES + 1);
  localparam logic [PW-1:0] PULL_LOAD = PW'(PULL_CYCLES - 1);

  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_low;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= `ICW_SYNC_RST;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= `ICW_PIN_IDLE;
      pin_sync_q <= `ICW_PIN_IDLE;
    end else begin
      pin_meta_q <= reset_pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // a low pin, ours or from outside, is a system reset for this block
  assign pin_low = !pin_sync_q;

  logic sys_reset;
  logic reload;
  logic uf;
  logic is_service;
  logic is_disable;
  logic is_other;
  logic en_set;
  logic fire;

  assign sys_reset = sys_reset_req | pin_low;
  assign reload = sys_reset | pd_entry;
  assign is_service = instr.exec && (instr.op == ICW_OP_SERVICE);
  assign is_disable = instr.exec && (instr.op == ICW_OP_DISABLE);
  assign is_other = instr.exec && (instr.op != ICW_OP_SERVICE) && (instr.op != ICW_OP_DISABLE);
  assign en_set = sys_reset | ram_backup_entry | pd_return;

  icw_down_counter #(
    .WIDTH(CNT_W)
  ) u_counter (
    .clk(clk),
    .rst_n(rst_n),
    .tick(cycle_tick),
    .reload(reload),
    .count_q(wd_count),
    .underflow_q(uf)
  );

  // flags and disable arming
  logic first_d, first_q;
  logic second_d, second_q;
  logic enable_d, enable_q;
  logic armed_d, armed_q;
  logic skip_d, skip_q;

  // a service in the underflow cycle counts as served, so no fire
  assign fire = uf && first_q && enable_q && !is_service && !sys_reset;

  always_comb begin
    first_d = first_q;
    second_d = second_q;
    enable_d = enable_q;
    armed_d = armed_q;
    skip_d = 1'b0;
    if (is_service || pd_entry) begin
      first_d = 1'b0;
    end
    if (uf) begin
      // set beats a service or power-down clear in the same cycle; a system reset still clears
      first_d = 1'b1;
    end
    if (fire) begin
      second_d = 1'b1;
    end
    if (sys_reset_req) begin
      second_d = 1'b0;
    end
    if (instr.exec) begin
      // only the instruction right after a disable may complete it
      armed_d = is_disable;
    end
    if (is_service) begin
      skip_d = first_q;
      if (armed_q) begin
        enable_d = 1'b0;
      end
    end
    if (en_set) begin
      enable_d = 1'b1;
    end
    if (sys_reset) begin
      first_d = 1'b0;
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b0;
      second_q <= 1'b0;
      enable_q <= 1'b1;
      armed_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      first_q <= first_d;
      second_q <= second_d;
      enable_q <= enable_d;
      armed_q <= armed_d;
      skip_q <= skip_d;
    end
  end

  // reset pin driver: pull low for a fixed time, then wait for the pin to rise
  icw_state_t state_d, state_q;
  logic [PW-1:0] pull_cnt_d, pull_cnt_q;
  logic oe_d, oe_q;
  logic pin_o_q;

  always_comb begin
    state_d = state_q;
    pull_cnt_d = pull_cnt_q;
    case (state_q)
      ICW_ST_RUN: begin
        if (fire) begin
          state_d = ICW_ST_PULL;
          pull_cnt_d = PULL_LOAD;
        end
      end
      ICW_ST_PULL: begin
        if (pull_cnt_q == '0) begin
          state_d = ICW_ST_WAIT;
        end else begin
          pull_cnt_d = pull_cnt_q - PW'(1);
        end
      end
      ICW_ST_WAIT: begin
        // a pin held low from outside keeps us here, not re-firing
        if (!pin_low) begin
          state_d = ICW_ST_RUN;
        end
      end
      default: begin
        state_d = ICW_ST_RUN;
        pull_cnt_d = '0;
      end
    endcase
    oe_d = (state_d == ICW_ST_PULL);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ICW_ST_RUN;
      pull_cnt_q <= '0;
      oe_q <= 1'b0;
      pin_o_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pull_cnt_q <= pull_cnt_d;
      oe_q <= oe_d;
      pin_o_q <= 1'b0;
    end
  end

  assign reset_pin_o = pin_o_q;
  assign reset_pin_oe = oe_q;
  assign skip_next = skip_q;
  assign wd_enable_flag = enable_q;
  assign first_underflow_flag = first_q;
  assign second_underflow_flag = second_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [PW:0] oe_run_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_run_q <= '0;
    end else if (oe_q) begin
      oe_run_q <= oe_run_q + (PW+1)'(1);
    end else begin
      oe_run_q <= '0;
    end
  end

  AST_RELOAD_ONES: assert property (
    reload |=> wd_count == {CNT_W{1'b1}})
    else $error("counter not all ones after reload");

  AST_DECREMENT: assert property (
    cycle_tick && !reload && wd_count != '0 |=> wd_count == $past(wd_count) - CNT_W'(1))
    else $error("counter did not decrement by one");

  AST_WRAP: assert property (
    cycle_tick && !reload && wd_count == '0 |=> uf && wd_count == {CNT_W{1'b1}})
    else $error("counter did not wrap to all ones with underflow");

  AST_UF_SETS_FIRST: assert property (
    uf && !sys_reset |=> first_q)
    else $error("underflow did not set first flag");

  AST_FIRE_PULLS: assert property (
    state_q == ICW_ST_RUN && fire |=> second_q && state_q == ICW_ST_PULL && reset_pin_oe && !reset_pin_o)
    else $error("second underflow did not pull reset pin");

  AST_NO_FIRE_DISABLED: assert property (
    state_q == ICW_ST_RUN && !enable_q |=> state_q == ICW_ST_RUN)
    else $error("watchdog reset acted while disabled");

  AST_DISABLE_PAIR: assert property (
    is_service && armed_q && !en_set |=> !enable_q)
    else $error("disable then service did not clear enable");

  AST_ENABLE_SET: assert property (
    en_set |=> enable_q)
    else $error("enable flag not set by reset, back-up or return");

  AST_SKIP: assert property (
    is_service && first_q |=> skip_next ##1 !skip_next)
    else $error("service with first flag set did not skip once");

  AST_NO_SKIP: assert property (
    is_service && !first_q |=> !skip_next)
    else $error("service with first flag clear skipped");

  AST_SKIP_DISABLED: assert property (
    is_service && first_q && !enable_q && !uf |=> skip_next && !first_q)
    else $error("skip or clear lost while disabled");

  // the run counter still holds the full length at the edge that sees the fall
  AST_PULL_LENGTH: assert property (
    $fell(reset_pin_oe) |-> oe_run_q == (PW+1)'(PULL_CYCLES))
    else $error("reset pull-down length wrong");

  AST_LONE_DISABLE: assert property (
    is_disable |=> !$fell(enable_q))
    else $error("lone disable stopped the watchdog");

  AST_POWER_DOWN: assert property (
    pd_entry && !uf |=> !first_q && wd_count == {CNT_W{1'b1}})
    else $error("power-down entry did not reinitialise");

  AST_PD_RETURN: assert property (
    pd_return ##1 !(is_service && armed_q) |=> enable_q)
    else $error("watchdog not active after power-down return");

  AST_ARM_CANCEL: assert property (
    is_other |=> !armed_q)
    else $error("pending disable survived another instruction");

  AST_NO_PAIR: assert property (
    is_service && !armed_q && enable_q |=> enable_q)
    else $error("service without a pending disable cleared enable");

endmodule

// file: tb/icw_core_model.sv
module icw_core_model import icw_pkg::*; (
  input wire logic clk,
  input wire logic skip_next,
  output icw_instr_t instr,
  output logic pd_entry,
  output logic pd_return
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    instr = '{exec: 1'b0, op: ICW_OP_OTHER};
    pd_entry = 1'b0;
    pd_return = 1'b0;
  end
  // one retire strobe; skip is read in the cycle after it
  task automatic run(input icw_op_t op, output logic skip);
    @(posedge clk);
    instr <= '{exec: 1'b1, op: op};
    @(posedge clk);
    instr <= '{exec: 1'b0, op: ICW_OP_OTHER};
    @(negedge clk);
    skip = skip_next;
  endtask
  // svc=0 models a program that forgets to service first
  task automatic enter_pd(input bit svc);
    logic s;
    if (svc) run(ICW_OP_SERVICE, s);
    @(posedge clk);
    pd_entry <= 1'b1;
    @(posedge clk);
    pd_entry <= 1'b0;
    @(negedge clk);
  endtask
  task automatic leave_pd(input bit use_wd);
    logic s;
    @(posedge clk);
    pd_return <= 1'b1;
    @(posedge clk);
    pd_return <= 1'b0;
    if (!use_wd) begin
      run(ICW_OP_DISABLE, s);
      run(ICW_OP_SERVICE, s);
    end
    @(negedge clk);
  endtask
endmodule

// file: tb/icw_watchdog_tb.sv
module icw_watchdog_tb import icw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 256;
  localparam int PULL = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cycle_tick = 1'b0;
  logic sys_reset_req = 1'b0;
  logic ram_backup_entry = 1'b0;
  icw_instr_t instr;
  logic pd_entry, pd_return, reset_pin_i;
  logic reset_pin_o, reset_pin_oe, skip_next;
  logic wd_enable_flag, first_underflow_flag, second_underflow_flag;
  logic [7:0] wd_count;
  logic sk;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  // open-drain pin with a pull-up
  assign reset_pin_i = reset_pin_oe ? reset_pin_o : 1'b1;
  icw_watchdog #(.CNT_W(8), .PULL_CYCLES(PULL)) dut (
    .clk(clk), .arst_n(arst_n), .cycle_tick(cycle_tick), .instr(instr),
    .sys_reset_req(sys_reset_req), .ram_backup_entry(ram_backup_entry),
    .pd_entry(pd_entry), .pd_return(pd_return), .reset_pin_i(reset_pin_i),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .skip_next(skip_next),
    .wd_enable_flag(wd_enable_flag), .first_underflow_flag(first_underflow_flag),
    .second_underflow_flag(second_underflow_flag), .wd_count(wd_count)
  );
  icw_core_model core (
    .clk(clk), .skip_next(skip_next), .instr(instr),
    .pd_entry(pd_entry), .pd_return(pd_return)
  );
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    @(posedge clk);
    cycle_tick <= 1'b1;
    repeat (n) @(posedge clk);
    cycle_tick <= 1'b0;
    @(negedge clk);
  endtask
  // flag lands one edge after the wrap
  task automatic underflow();
    ticks(N);
    @(negedge clk);
  endtask
  task automatic t_reset();
    chk(wd_count, 16'h00ff);
    chk(wd_enable_flag, 16'h0001);
    chk(first_underflow_flag, 16'h0000);
    chk(reset_pin_oe, 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_count();
    ticks(3);
    chk(wd_count, 16'h00fc);
    ticks(N - 4);
    chk(wd_count, 16'h0000);
    chk(first_underflow_flag, 16'h0000);
    ticks(1);
    chk(wd_count, 16'h00ff);
    @(negedge clk);
    chk(first_underflow_flag, 16'h0001);
    $display("t_count done");
  endtask
  task automatic t_service();
    core.run(ICW_OP_SERVICE, sk);
    chk(sk, 16'h0001);
    chk(first_underflow_flag, 16'h0000);
    core.run(ICW_OP_SERVICE, sk);
    chk(sk, 16'h0000);
    $display("t_service done");
  endtask
  task automatic t_fire();
    int n;
    underflow();
    chk(first_underflow_flag, 16'h0001);
    ticks(N);
    @(negedge clk);
    chk(second_underflow_flag, 16'h0001);
    chk(reset_pin_o, 16'h0000);
    n = 0;
    while (reset_pin_oe === 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    chk(n[15:0], PULL[15:0]);
    repeat (3) @(negedge clk);
    chk(first_underflow_flag, 16'h0000);
    chk(wd_count, 16'h00ff);
    chk(second_underflow_flag, 16'h0001);
    @(posedge clk);
    sys_reset_req <= 1'b1;
    @(posedge clk);
    sys_reset_req <= 1'b0;
    @(negedge clk);
    chk(second_underflow_flag, 16'h0000);
    $display("t_fire done");
  endtask
  task automatic t_disable();
    int n;
    core.run(ICW_OP_DISABLE, sk);
    core.run(ICW_OP_OTHER, sk);
    core.run(ICW_OP_SERVICE, sk);
    chk(wd_enable_flag, 16'h0001);
    core.run(ICW_OP_DISABLE, sk);
    core.run(ICW_OP_SERVICE, sk);
    chk(wd_enable_flag, 16'h0000);
    underflow();
    ticks(N);
    n = 0;
    repeat (PULL + 4) begin
      @(negedge clk);
      if (reset_pin_oe !== 1'b0) n++;
    end
    chk(n[15:0], 16'h0000);
    chk(second_underflow_flag, 16'h0000);
    core.run(ICW_OP_SERVICE, sk);
    chk(sk, 16'h0001);
    @(posedge clk);
    ram_backup_entry <= 1'b1;
    @(posedge clk);
    ram_backup_entry <= 1'b0;
    @(negedge clk);
    chk(wd_enable_flag, 16'h0001);
    $display("t_disable done");
  endtask
  task automatic t_pd();
    underflow();
    ticks(5);
    chk(wd_count, 16'h00fa);
    core.enter_pd(1'b0);
    chk(first_underflow_flag, 16'h0000);
    chk(wd_count, 16'h00ff);
    core.leave_pd(1'b0);
    chk(wd_enable_flag, 16'h0000);
    core.enter_pd(1'b1);
    core.leave_pd(1'b1);
    chk(wd_enable_flag, 16'h0001);
    $display("t_pd done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    t_reset();
    t_count();
    t_service();
    t_fire();
    t_disable();
    t_pd();
    test_done();
  end
endmodule
